// ### kcg_pkg.sv
`default_nettype none

package kcg_pkg;
	localparam int          CLK_HZ             = 25_000_000;
	localparam int          TYPEMATIC_DELAY_MS = 500;
	localparam int          REPEAT_RATE_MIN_HZ = 10;
	localparam int          REPEAT_RATE_MAX_HZ = 12;
	localparam int          USB_BIT_RATE_HZ    = 1_500_000;
	// held longer than the delay: exact multiple, so no rounding needed
	localparam int          TYPEMATIC_DELAY_CYCLES = (CLK_HZ / 1000) * TYPEMATIC_DELAY_MS;
	// midpoint of the allowed rate band keeps both limits met
	localparam int          REPEAT_PERIOD_CYCLES =
		(2 * CLK_HZ) / (REPEAT_RATE_MIN_HZ + REPEAT_RATE_MAX_HZ);
	localparam int          USB_BIT_DIV        = CLK_HZ / USB_BIT_RATE_HZ;
	localparam int          CNT_W              = 24;
	localparam int          DIV_W              = 5;
	localparam int          QUEUE_DEPTH        = 16;
	localparam int          QUEUE_AW           = 4;
	localparam int          USB_FRAME_BITS     = 16;
	localparam int          USB_STUFF_RUN      = 6;
	localparam logic [7:0]  BREAK_PREFIX       = 8'hF0;
	localparam logic [7:0]  OVERRUN_CODE       = 8'h00;
	localparam logic [7:0]  SELFCHECK_OK_CODE  = 8'hAA;
	localparam logic [7:0]  USB_SYNC_PATTERN   = 8'h80;
	localparam logic [6:0]  PAUSE_POS          = 7'h10;

	typedef enum logic [1:0] {SRC_NONE, SRC_SELFCHECK, SRC_REPEAT, SRC_QUEUE} kcg_src_e;
	typedef enum logic [1:0] {OVR_SRC_IDLE, OVR_SRC_SEND} kcg_unused_e;
	typedef enum logic [1:0] {USB_IDLE, USB_SEND, USB_EOP} kcg_usb_e;
endpackage

`default_nettype wire

// ### kcg_queue_if.sv
`default_nettype none

interface kcg_queue_if;
	logic       push;
	logic [7:0] push_data;
	logic       pop;
	logic [7:0] head;
	logic       empty;
	logic [4:0] free;

	modport store (input push, push_data, pop, output head, empty, free);
	modport user  (output push, push_data, pop, input head, empty, free);
endinterface

`default_nettype wire

// ### kcg_byte_queue.sv
`default_nettype none

module kcg_byte_queue
	import kcg_pkg::*;
(
	// clock and reset
	input  wire logic   core_clk_i,
	input  wire logic   rst_i,
	// queue port
	kcg_queue_if.store  q
);
	logic [7:0]          mem [QUEUE_DEPTH];
	logic [QUEUE_AW-1:0] wr_ptr;
	logic [QUEUE_AW-1:0] rd_ptr;
	logic [4:0]          count;
	logic                do_push;
	logic                do_pop;

	// push beyond full is refused here; the producer checks free first
	assign do_push = q.push && (count != 5'(QUEUE_DEPTH));
	assign do_pop  = q.pop && (count != 5'h00);

	assign q.head  = mem[rd_ptr];
	assign q.empty = (count == 5'h00);
	assign q.free  = 5'(QUEUE_DEPTH) - count;

	always_ff @(posedge core_clk_i) begin
		if (do_push) begin
			mem[wr_ptr] <= q.push_data;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + 4'h1;
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + 4'h1;
			end
			if (do_push && !do_pop) begin
				count <= count + 5'h01;
			end else if (do_pop && !do_push) begin
				count <= count - 5'h01;
			end
		end
	end
endmodule

`default_nettype wire

// ### kcg_keystroke_gen.sv
`default_nettype none

module kcg_keystroke_gen
	import kcg_pkg::*;
#(
	parameter int TYPEMATIC_DELAY_CYC = TYPEMATIC_DELAY_CYCLES,
	parameter int REPEAT_PERIOD_CYC   = REPEAT_PERIOD_CYCLES
) (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// key events from the matrix scanner
	input  wire logic       key_event_i,
	input  wire logic       key_down_i,
	input  wire logic [7:0] key_code_i,
	input  wire logic [6:0] key_pos_i,
	input  wire logic       key_shortcut_i,
	// variant strap pin
	input  wire logic       usb_mode_i,
	// byte stream to the serial framer
	input  wire logic       host_ready_i,
	output logic [7:0]      byte_o,
	output logic            byte_valid_o,
	// usb line
	output logic            usb_nrzi_o,
	output logic            usb_oe_o
);
	import kcg_pkg::*;

	kcg_queue_if q ();

	kcg_byte_queue u_queue (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.q          (q)
	);

	function automatic logic fits(input logic [4:0] free, input logic [1:0] need,
		input logic held);
		fits = {1'b0, free} >= ({4'h0, need} + {5'h00, held});
	endfunction

	logic              mode_s1;
	logic              mode_s2;
	logic              mode_s3;
	logic              usb_mode;
	logic              hold_valid;
	logic [7:0]        hold_data;
	logic              overrun_pending;
	logic              selfcheck_pending;
	logic              rep_active;
	logic              rep_first;
	logic              rep_pending;
	logic [7:0]        rep_code;
	logic [CNT_W-1:0]  rep_cnt;
	logic              is_pause;
	logic              no_repeat;
	logic [1:0]        need;
	logic              accept;
	logic              overflow;
	kcg_src_e          src;
	logic [7:0]        src_byte;
	logic              slot_free;
	logic              take;
	kcg_usb_e          usb_state;
	logic [DIV_W-1:0]  div_cnt;
	logic              bit_en;
	logic [15:0]       usb_shift;
	logic [4:0]        usb_bits;
	logic [2:0]        ones_run;

	// three-flop pin sync; mode moves only when the last two stages agree
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			mode_s1  <= 1'b0;
			mode_s2  <= 1'b0;
			mode_s3  <= 1'b0;
			usb_mode <= 1'b0;
		end else begin
			mode_s1 <= usb_mode_i;
			mode_s2 <= mode_s1;
			mode_s3 <= mode_s2;
			if (mode_s2 == mode_s3) begin
				usb_mode <= mode_s3;
			end
		end
	end

	always_comb begin
		is_pause  = (key_pos_i == PAUSE_POS);
		no_repeat = is_pause || key_shortcut_i;
		if (key_down_i) begin
			need = 2'd1;
		end else if (is_pause) begin
			need = 2'd0;
		end else begin
			need = 2'd2;
		end
		// a sequence is taken only whole; otherwise it turns into an overrun
		accept   = key_event_i && !overrun_pending && !hold_valid && (need != 2'd0)
			&& fits(q.free, need, 1'b0);
		overflow = key_event_i && !overrun_pending && !hold_valid && (need != 2'd0)
			&& !accept;
	end

	// queue feed: first byte of a sequence, then the held second byte
	always_comb begin
		q.push      = hold_valid || accept;
		q.push_data = hold_valid ? hold_data : (key_down_i ? key_code_i : BREAK_PREFIX);
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			hold_valid <= 1'b0;
			hold_data  <= 8'h00;
		end else begin
			hold_valid <= accept && !key_down_i;
			if (accept) begin
				hold_data <= key_code_i;
			end
		end
	end

	// overrun: the code stands in for the lost byte, scans dropped until it is sent
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			overrun_pending <= 1'b0;
		end else if (overflow) begin
			overrun_pending <= 1'b1;
		end else if (take && src == SRC_NONE) begin
			overrun_pending <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			selfcheck_pending <= 1'b1;
		end else if (take && src == SRC_SELFCHECK) begin
			selfcheck_pending <= 1'b0;
		end
	end

	// typematic: only the latest pressed key is tracked, so earlier ones stop
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rep_active  <= 1'b0;
			rep_first   <= 1'b0;
			rep_pending <= 1'b0;
			rep_code    <= 8'h00;
			rep_cnt     <= '0;
		end else begin
			if (take && src == SRC_REPEAT) begin
				rep_pending <= 1'b0;
			end
			if (key_event_i && key_down_i) begin
				rep_active  <= !no_repeat;
				rep_code    <= key_code_i;
				rep_first   <= 1'b1;
				rep_cnt     <= '0;
				rep_pending <= 1'b0;
			end else if (key_event_i && rep_active && key_code_i == rep_code) begin
				rep_active  <= 1'b0;
				rep_pending <= 1'b0;
			end else if (rep_active) begin
				if (rep_cnt == CNT_W'((rep_first ? TYPEMATIC_DELAY_CYC : REPEAT_PERIOD_CYC) - 1))
				begin
					rep_cnt     <= '0;
					rep_first   <= 1'b0;
					rep_pending <= 1'b1;
				end else begin
					rep_cnt <= rep_cnt + 1'b1;
				end
			end
		end
	end

	// source priority: responses and repeats bypass the queue; overrun goes last
	always_comb begin
		if (selfcheck_pending) begin
			src      = SRC_SELFCHECK;
			src_byte = SELFCHECK_OK_CODE;
		end else if (rep_pending) begin
			src      = SRC_REPEAT;
			src_byte = rep_code;
		end else if (!q.empty) begin
			src      = SRC_QUEUE;
			src_byte = q.head;
		end else begin
			src      = SRC_NONE;
			src_byte = OVERRUN_CODE;
		end
		slot_free = usb_mode ? (usb_state == USB_IDLE) : (!byte_valid_o || host_ready_i);
		take      = slot_free && (src != SRC_NONE || overrun_pending);
		q.pop     = take && (src == SRC_QUEUE);
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			byte_valid_o <= 1'b0;
			byte_o       <= 8'h00;
		end else if (!usb_mode && slot_free) begin
			byte_valid_o <= take;
			if (take) begin
				byte_o <= src_byte;
			end
		end else if (usb_mode) begin
			byte_valid_o <= 1'b0;
		end
	end

	// bit-rate enable for the usb line
	always_ff @(posedge core_clk_i) begin
		if (rst_i || usb_state == USB_IDLE) begin
			div_cnt <= '0;
			bit_en  <= 1'b0;
		end else if (div_cnt == DIV_W'(USB_BIT_DIV - 1)) begin
			div_cnt <= '0;
			bit_en  <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			bit_en  <= 1'b0;
		end
	end

	// sync then data, lsb first, nrzi with a stuffed transition after six ones;
	// end of packet: the last level is driven for its own bit time only, then the line is released
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			usb_state  <= USB_IDLE;
			usb_shift  <= 16'h0000;
			usb_bits   <= '0;
			ones_run   <= '0;
			usb_nrzi_o <= 1'b1;
			usb_oe_o   <= 1'b0;
		end else begin
			case (usb_state)
				USB_IDLE: begin
					usb_nrzi_o <= 1'b1;
					usb_oe_o   <= 1'b0;
					if (usb_mode && take) begin
						usb_shift <= {src_byte, USB_SYNC_PATTERN};
						usb_bits  <= '0;
						ones_run  <= '0;
						usb_oe_o  <= 1'b1;
						usb_state <= USB_SEND;
					end
				end
				USB_SEND: begin
					if (bit_en) begin
						if (ones_run == 3'(USB_STUFF_RUN)) begin
							usb_nrzi_o <= !usb_nrzi_o;
							ones_run   <= '0;
						end else begin
							if (!usb_shift[0]) begin
								usb_nrzi_o <= !usb_nrzi_o;
								ones_run   <= '0;
							end else begin
								ones_run <= ones_run + 3'h1;
							end
							usb_shift <= {1'b0, usb_shift[15:1]};
							usb_bits  <= usb_bits + 5'h01;
							if (usb_bits == 5'(USB_FRAME_BITS - 1)) begin
								usb_state <= USB_EOP;
							end
						end
					end
				end
				USB_EOP: begin
					if (bit_en) begin
						usb_oe_o   <= 1'b0;
						usb_nrzi_o <= 1'b1;
						usb_state  <= USB_IDLE;
					end
				end
				default: begin
					usb_state <= USB_IDLE;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// ### kcg_sva.sv
`default_nettype none

module kcg_sva
	import kcg_pkg::*;
(
	// watched ports
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       key_event_i,
	input  wire logic       key_down_i,
	input  wire logic [6:0] key_pos_i,
	input  wire logic       host_ready_i,
	input  wire logic [7:0] byte_o,
	input  wire logic       byte_valid_o,
	input  wire logic       usb_nrzi_o,
	input  wire logic       usb_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	hold_byte_a: assert property (byte_valid_o && !host_ready_i |=>
		byte_valid_o && $stable(byte_o)) else $error("byte lost under stall");
	drop_accept_a: assert property ($fell(byte_valid_o) |-> $past(host_ready_i))
		else $error("byte withdrawn unaccepted");
	reset_idle_a: assert property (disable iff (1'b0) rst_i |=>
		!byte_valid_o && usb_nrzi_o && !usb_oe_o) else $error("bad reset outputs");
	selfcheck_first_a: assert property ($fell(rst_i) |=>
		byte_valid_o && byte_o == SELFCHECK_OK_CODE) else $error("no self-check byte");
	line_idle_a: assert property (!usb_oe_o |-> usb_nrzi_o)
		else $error("usb line not idle high");
	one_path_a: assert property (usb_oe_o |-> !byte_valid_o)
		else $error("both outputs active");
	// in usb mode the frame on the line stands in for the byte strobe
	press_out_a: assert property (key_event_i && key_down_i |->
		##[1:4] (byte_valid_o || usb_oe_o)) else $error("press gave no byte");
	// pause release is the one event allowed to stay silent
	release_out_a: assert property (key_event_i && !key_down_i &&
		key_pos_i != PAUSE_POS |-> ##[1:4] (byte_valid_o || usb_oe_o))
		else $error("release gave no byte");
endmodule

`default_nettype wire

// ### kcg_host_model.sv
`default_nettype none

module kcg_host_model (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// byte stream from the keyboard
	input  wire logic [7:0] byte_i,
	input  wire logic       byte_valid_i,
	output logic            host_ready_o,
	// scenario control: hold the keyboard off
	input  wire logic       stall_i,
	// decoded keyboard bytes
	output logic            system_management_interrupt_o,
	output logic [7:0]      rx_byte_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ready is registered, so a stall lands one cycle late, as a real host would
	always_ff @(posedge core_clk_i) begin
		host_ready_o <= !rst_i && !stall_i;
		system_management_interrupt_o <= !rst_i && byte_valid_i && host_ready_o;
		rx_byte_o <= byte_i;
	end
endmodule

`default_nettype wire

// ### tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic       core_clk_i = 1'b0;
	logic       rst_i      = 1'b1;
	logic       ev         = 1'b0;
	logic       dn         = 1'b0;
	logic       sc         = 1'b0;
	logic       stall      = 1'b0;
	logic [7:0] code       = 8'h00;
	logic [6:0] pos        = 7'h00;
	logic       usb_mode   = 1'b0;
	wire        ready;
	wire        system_management_interrupt;
	wire        valid;
	wire  [7:0] rxd;
	wire  [7:0] bo;
	wire        nrzi;
	wire        oe;
	logic [7:0] got[$];
	int         failures        = 0;
	int         samples_checked = 0;

	always #20 core_clk_i = ~core_clk_i;

	kcg_keystroke_gen #(.TYPEMATIC_DELAY_CYC(50), .REPEAT_PERIOD_CYC(20)) dut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .key_event_i(ev), .key_down_i(dn),
		.key_code_i(code), .key_pos_i(pos), .key_shortcut_i(sc), .usb_mode_i(usb_mode),
		.host_ready_i(ready), .byte_o(bo), .byte_valid_o(valid),
		.usb_nrzi_o(nrzi), .usb_oe_o(oe));

	kcg_host_model host (.core_clk_i(core_clk_i), .rst_i(rst_i), .byte_i(bo),
		.byte_valid_i(valid), .host_ready_o(ready), .stall_i(stall),
		.system_management_interrupt_o(system_management_interrupt), .rx_byte_o(rxd));

	always @(posedge core_clk_i) if (system_management_interrupt) got.push_back(rxd);

	task automatic give_verdict();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	// events keep a two-cycle gap, so none lands while a release's second byte is pushed
	task automatic key(input logic [7:0] c, input logic [6:0] p, input logic d, input logic s);
		ev <= 1'b1;
		code <= c;
		pos <= p;
		dn <= d;
		sc <= s;
		tick(1);
		ev <= 1'b0;
		tick(2);
	endtask

	task automatic expect_byte(input logic [7:0] exp);
		for (int i = 0; i < 3000 && got.size() == 0; i++) tick(1);
		if (got.size() == 0) begin
			failures++;
			$display("CHECK FAILED at %0t: no byte", $time);
			give_verdict();
		end else begin
			check_val(got.pop_front(), exp);
		end
	endtask

	task automatic t_make_break();
		key(8'h1C, 7'h1E, 1'b1, 1'b0);
		key(8'h1C, 7'h1E, 1'b0, 1'b0);
		expect_byte(8'h1C);
		expect_byte(8'hF0);
		expect_byte(8'h1C);
		$display("test make_break done");
	endtask

	task automatic t_no_repeat();
		key(8'hE1, 7'h10, 1'b1, 1'b0);
		key(8'hE1, 7'h10, 1'b0, 1'b0);
		key(8'h3B, 7'h64, 1'b1, 1'b1);
		tick(150);
		key(8'h3B, 7'h64, 1'b0, 1'b1);
		expect_byte(8'hE1);
		expect_byte(8'h3B);
		expect_byte(8'hF0);
		expect_byte(8'h3B);
		tick(20);
		check_val(8'(got.size()), 8'h00);
		$display("test no_repeat done");
	endtask

	task automatic t_repeat();
		key(8'h1C, 7'h1E, 1'b1, 1'b0);
		tick(10);
		key(8'h32, 7'h1F, 1'b1, 1'b0);
		tick(100);
		key(8'h32, 7'h1F, 1'b0, 1'b0);
		key(8'h1C, 7'h1E, 1'b0, 1'b0);
		expect_byte(8'h1C);
		for (int i = 0; i < 4; i++) expect_byte(8'h32);
		expect_byte(8'hF0);
		expect_byte(8'h32);
		expect_byte(8'hF0);
		expect_byte(8'h1C);
		tick(60);
		check_val(8'(got.size()), 8'h00);
		$display("test repeat done");
	endtask

	// one byte waits in the output register, so the 18th press is the overflow
	task automatic t_overrun();
		stall <= 1'b1;
		for (int i = 0; i < 18; i++) key(8'h40 + 8'(i), 7'h28 + 7'(i), 1'b1, 1'b1);
		stall <= 1'b0;
		for (int i = 0; i < 17; i++) expect_byte(8'h40 + 8'(i));
		expect_byte(8'h00);
		key(8'h1C, 7'h1E, 1'b1, 1'b1);
		expect_byte(8'h1C);
		$display("test overrun done");
	endtask

	// 7Eh holds six ones in a row, so the frame must carry one stuffed toggle;
	// the line is read mid-bit, eight cycles after each bit edge
	task automatic t_usb();
		logic [15:0] bits;
		logic        prev;
		int          run;
		int          n;
		usb_mode <= 1'b1;
		tick(8);
		key(8'h7E, 7'h70, 1'b1, 1'b1);
		for (int i = 0; i < 50 && !oe; i++) tick(1);
		check_val({7'h00, oe}, 8'h01);
		if (!oe) give_verdict();
		tick(24);
		prev = 1'b1;
		run  = 0;
		n    = 0;
		bits = 16'h0000;
		for (int k = 0; k < 17; k++) begin
			if (run == 6) begin
				check_val({7'h00, nrzi ^ prev}, 8'h01);
				run = 0;
			end else begin
				bits[n] = (nrzi == prev);
				run     = (nrzi == prev) ? run + 1 : 0;
				n++;
			end
			prev = nrzi;
			tick(16);
		end
		check_val(bits[7:0], 8'h80);
		check_val(bits[15:8], 8'h7E);
		check_val({6'h00, oe, nrzi}, 8'h01);
		check_val(8'(got.size()), 8'h00);
		$display("test usb done");
	endtask

	initial begin
		tick(16);
		rst_i <= 1'b0;
		expect_byte(8'hAA);
		t_make_break();
		t_no_repeat();
		t_repeat();
		t_overrun();
		t_usb();
		give_verdict();
	end
endmodule

bind kcg_keystroke_gen kcg_sva u_sva (.core_clk_i, .rst_i, .key_event_i, .key_down_i,
	.key_pos_i, .host_ready_i, .byte_o, .byte_valid_o, .usb_nrzi_o, .usb_oe_o);

`default_nettype wire
